// >>> rtl/vec_pkg.sv
// Operation
// - IRQ status bit is source active, channel enabled and routed to IRQ.
// - Status bits never latch; they follow the source until the peripheral clears.
// - Raw status is source OR software trigger, before any masking.
// - Route bit 0 sends channel to IRQ, 1 to FIQ; resets to 0.
// - Writing 1 sets a channel enable, 0 leaves it; all masked at reset.
// - Writing 1 to enable-clear clears that channel enable; 0 does nothing.
// - Writing 1 sets a software trigger bit; 0 does nothing; resets to zero.
// - Writing 1 to trigger-clear clears that software trigger bit; 0 does nothing.
// - Write-only bits read back their reset value; set-only bits ignore zeros.
// - Protection bit 1 admits privileged accesses only; bits 15:1 read zero.
// - Reading current vector returns active handler and marks it in service.
// - Any write to current vector ends service, reopening equal and lower priority.
// - A writable fallback handler address register resets to zero.
// - Sixteen handler slots reset to zero; slot 0 highest, slot 15 lowest priority.
// - Each slot has a 5-bit source field choosing its input channel.
// - Slot enable flag at bit 5 resets to 0; slot vectors only when set.
// - The IRQ request is the OR of active enabled channels routed to IRQ.
package vec_pkg;
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int SLOT_AW = 4;
  // Register offsets
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h000;
  localparam logic [11:0] OFF_FIQ_STATUS = 12'h004;
  localparam logic [11:0] OFF_RAW_STATUS = 12'h008;
  localparam logic [11:0] OFF_ROUTE = 12'h00c;
  localparam logic [11:0] OFF_ENABLE_SET = 12'h010;
  localparam logic [11:0] OFF_ENABLE_CLR = 12'h014;
  localparam logic [11:0] OFF_SOFT_SET = 12'h018;
  localparam logic [11:0] OFF_SOFT_CLR = 12'h01c;
  localparam logic [11:0] OFF_PROTECT = 12'h020;
  localparam logic [11:0] OFF_ACTIVE = 12'h030;
  localparam logic [11:0] OFF_FALLBACK = 12'h034;
  localparam logic [11:0] OFF_SLOT_ADDR = 12'h100;
  localparam logic [11:0] OFF_SLOT_CTRL = 12'h200;
  // Slot control fields
  localparam int SLOT_SRC_LSB = 0;
  localparam int SLOT_SRC_W = 5;
  localparam int SLOT_EN_BIT = 5;
  localparam int SLOT_CTRL_W = 6;
  localparam int PRIV_ONLY_BIT = 0;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] RST_SLOT_CTRL = 6'h00;
  localparam logic RST_PRIV_ONLY = 1'b0;
  // Cycles from a taken request to its answer
  localparam int ANSWER_CYCLES = 2;
endpackage

// >>> rtl/vec_slot_if.sv
`timescale 1ns/10ps
// Handler slot storage port between the controller and its memory
interface vec_slot_if #(
  parameter int AW = 4,
  parameter int DW = 16
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> rtl/vec_slot_mem.sv
`timescale 1ns/10ps
module vec_slot_mem #(
  parameter int DEPTH = 16,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Storage port
  vec_slot_if.mem port
);
  import vec_pkg::*;

  logic [DW-1:0] words [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Handler address words, all cleared at reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        words[i] <= DW'(RST_WORD);
      end
    end else if (port.wr_en) begin
      words[port.wr_addr] <= port.wr_data;
    end
  end

  // Registered read; a write in the same cycle shows on the next read only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      port.rd_data <= '0;
    end else begin
      port.rd_data <= words[port.rd_addr];
    end
  end
endmodule

// >>> rtl/vec_intc.sv
`timescale 1ns/10ps
module vec_intc (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Peripheral interrupt lines
  input wire logic [vec_pkg::NUM_CH-1:0] irq_source,
  // Register access port
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_priv,
  input wire logic [vec_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [vec_pkg::DATA_W-1:0] bus_wdata,
  output logic bus_ack,
  output logic bus_error,
  output logic [vec_pkg::DATA_W-1:0] bus_rdata,
  // Processor interrupt requests
  output logic irq_out,
  output logic fiq_out
);
  import vec_pkg::*;

  vec_slot_if #(.AW(SLOT_AW), .DW(DATA_W)) slot_bus ();

  logic [15:0] sync_a, sync_b, sync_c, chan_src;
  logic [15:0] fast_route_bits, channel_enable_bits, soft_trigger_bits;
  logic privileged_only_bit;
  logic [15:0] fallback_handler_field;
  logic [SLOT_CTRL_W-1:0] slot_ctrl [NUM_CH];
  logic [15:0] in_service;
  logic [15:0] raw_source_bits, irq_masked_bits, fiq_masked_bits;
  logic acc_ok, acc_wr, acc_rd, refused, mapped;
  logic var_rd, var_wr;
  logic [15:0] slot_cand;
  logic [4:0] service_lvl, win;
  logic has_win;
  logic st_valid, st_err, st_use_mem;
  logic [15:0] st_data, next_rdata;

  // Exact register match
  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Match within a 16-word slot table
  function automatic logic in_table(input logic [11:0] a, input logic [11:0] base);
    return a[11:6] == base[11:6] && a[1:0] == 2'b00;
  endfunction

  // Lowest set bit index, 16 when none; lower index is higher priority
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'd16;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Source synchronisers; a level counts once the second and third stages agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= irq_source;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Filtered source level; a one-cycle glitch never reaches the status bits
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_src <= '0;
    end else begin
      chan_src <= (sync_b & ~(sync_b ^ sync_c)) | (chan_src & (sync_b ^ sync_c));
    end
  end

  // Status is pure combination, so it falls in the same cycle as the filtered source level
  assign raw_source_bits = chan_src | soft_trigger_bits;
  assign irq_masked_bits = raw_source_bits & channel_enable_bits & ~fast_route_bits;
  assign fiq_masked_bits = raw_source_bits & channel_enable_bits & fast_route_bits;

  ////////////////////////////////////////////////////////////////////////////
  // Access qualification; protection guards every register, itself included
  assign acc_ok = bus_req && (!privileged_only_bit || bus_priv);
  assign acc_wr = acc_ok && bus_write;
  assign acc_rd = acc_ok && !bus_write;
  assign refused = bus_req && !acc_ok;
  assign var_rd = acc_rd && is_reg(bus_addr, OFF_ACTIVE);
  assign var_wr = acc_wr && is_reg(bus_addr, OFF_ACTIVE);

  // Address decode for the unmapped check
  assign mapped = is_reg(bus_addr, OFF_IRQ_STATUS) || is_reg(bus_addr, OFF_FIQ_STATUS)
    || is_reg(bus_addr, OFF_RAW_STATUS) || is_reg(bus_addr, OFF_ROUTE)
    || is_reg(bus_addr, OFF_ENABLE_SET) || is_reg(bus_addr, OFF_ENABLE_CLR)
    || is_reg(bus_addr, OFF_SOFT_SET) || is_reg(bus_addr, OFF_SOFT_CLR)
    || is_reg(bus_addr, OFF_PROTECT) || is_reg(bus_addr, OFF_ACTIVE)
    || is_reg(bus_addr, OFF_FALLBACK) || in_table(bus_addr, OFF_SLOT_ADDR)
    || in_table(bus_addr, OFF_SLOT_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Route select register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fast_route_bits <= RST_WORD;
    end else if (acc_wr && is_reg(bus_addr, OFF_ROUTE)) begin
      fast_route_bits <= bus_wdata;
    end
  end

  // Channel enables: separate set and clear addresses, ones act, zeros ignored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      channel_enable_bits <= RST_WORD;
    end else if (acc_wr && is_reg(bus_addr, OFF_ENABLE_SET)) begin
      channel_enable_bits <= channel_enable_bits | bus_wdata;
    end else if (acc_wr && is_reg(bus_addr, OFF_ENABLE_CLR)) begin
      channel_enable_bits <= channel_enable_bits & ~bus_wdata;
    end
  end

  // Software triggers, same set and clear scheme
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      soft_trigger_bits <= RST_WORD;
    end else if (acc_wr && is_reg(bus_addr, OFF_SOFT_SET)) begin
      soft_trigger_bits <= soft_trigger_bits | bus_wdata;
    end else if (acc_wr && is_reg(bus_addr, OFF_SOFT_CLR)) begin
      soft_trigger_bits <= soft_trigger_bits & ~bus_wdata;
    end
  end

  // Protection bit and fallback handler address
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      privileged_only_bit <= RST_PRIV_ONLY;
      fallback_handler_field <= RST_WORD;
    end else begin
      if (acc_wr && is_reg(bus_addr, OFF_PROTECT)) begin
        privileged_only_bit <= bus_wdata[PRIV_ONLY_BIT];
      end
      if (acc_wr && is_reg(bus_addr, OFF_FALLBACK)) begin
        fallback_handler_field <= bus_wdata;
      end
    end
  end

  // Slot control words: source field and enable flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        slot_ctrl[i] <= RST_SLOT_CTRL;
      end
    end else if (acc_wr && in_table(bus_addr, OFF_SLOT_CTRL)) begin
      slot_ctrl[bus_addr[5:2]] <= bus_wdata[SLOT_CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot candidates: enabled, source in range and pending, above current service
  assign service_lvl = first_set(in_service);
  for (genvar g = 0; g < NUM_CH; g++) begin : g_cand
    logic [SLOT_SRC_W-1:0] slot_source_select;
    assign slot_source_select = slot_ctrl[g][SLOT_SRC_LSB +: SLOT_SRC_W];
    // Codes 16 and up name no channel and never fire
    assign slot_cand[g] = slot_ctrl[g][SLOT_EN_BIT] && !slot_source_select[4]
      && irq_masked_bits[slot_source_select[3:0]] && (5'(g) < service_lvl);
  end
  assign win = first_set(slot_cand);
  assign has_win = !win[4];

  // In-service marks: read of current vector opens, write closes the top one
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_service <= RST_WORD;
    end else if (var_rd && has_win) begin
      in_service[win[3:0]] <= 1'b1;
    end else if (var_wr && !service_lvl[4]) begin
      in_service[service_lvl[3:0]] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handler address storage
  assign slot_bus.wr_en = acc_wr && in_table(bus_addr, OFF_SLOT_ADDR);
  assign slot_bus.wr_addr = bus_addr[5:2];
  assign slot_bus.wr_data = bus_wdata;
  assign slot_bus.rd_addr = var_rd ? win[3:0] : bus_addr[5:2];

  vec_slot_mem #(.DEPTH(NUM_CH), .DW(DATA_W)) u_slot_mem (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .port(slot_bus.mem)
  );

  // Read data chosen at the request edge, so status is sampled then
  always_comb begin
    next_rdata = RST_WORD;
    if (acc_rd) begin
      unique case (1'b1)
        is_reg(bus_addr, OFF_IRQ_STATUS): next_rdata = irq_masked_bits;
        is_reg(bus_addr, OFF_FIQ_STATUS): next_rdata = fiq_masked_bits;
        is_reg(bus_addr, OFF_RAW_STATUS): next_rdata = raw_source_bits;
        is_reg(bus_addr, OFF_ROUTE): next_rdata = fast_route_bits;
        is_reg(bus_addr, OFF_ENABLE_SET): next_rdata = channel_enable_bits;
        is_reg(bus_addr, OFF_SOFT_SET): next_rdata = soft_trigger_bits;
        is_reg(bus_addr, OFF_PROTECT): next_rdata = {15'h0000, privileged_only_bit};
        is_reg(bus_addr, OFF_ACTIVE): next_rdata = fallback_handler_field;
        is_reg(bus_addr, OFF_FALLBACK): next_rdata = fallback_handler_field;
        in_table(bus_addr, OFF_SLOT_CTRL): next_rdata = 16'(slot_ctrl[bus_addr[5:2]]);
        default: next_rdata = RST_WORD;
      endcase
    end
  end

  // First answer stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_valid <= 1'b0;
      st_err <= 1'b0;
      st_use_mem <= 1'b0;
      st_data <= RST_WORD;
    end else begin
      st_valid <= bus_req;
      st_err <= refused || (bus_req && !mapped);
      st_use_mem <= (acc_rd && in_table(bus_addr, OFF_SLOT_ADDR)) || (var_rd && has_win);
      st_data <= next_rdata;
    end
  end

  // Second stage drives the port; memory data arrive here from its own register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
      bus_error <= 1'b0;
      bus_rdata <= RST_WORD;
    end else begin
      bus_ack <= st_valid;
      bus_error <= st_err;
      bus_rdata <= st_use_mem ? slot_bus.rd_data : st_data;
    end
  end

  // Requests to the core, registered for clean timing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= 1'b0;
      fiq_out <= 1'b0;
    end else begin
      irq_out <= |irq_masked_bits;
      fiq_out <= |fiq_masked_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_refused;
    bus_req && !acc_ok;
  endsequence

  sequence s_var_hit;
    var_rd && has_win;
  endsequence

  sequence s_var_miss;
    var_rd && !has_win;
  endsequence

  property p_irq_route;
    |(chan_src & channel_enable_bits & ~fast_route_bits) |=> irq_out;
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("IRQ not raised");

  property p_fiq_route;
    (fiq_masked_bits == 16'h0000) |=> !fiq_out;
  endproperty
  a_fiq_route: assert property (p_fiq_route) else $error("FIQ without source");

  property p_enable_set;
    acc_wr && is_reg(bus_addr, OFF_ENABLE_SET)
      |=> (channel_enable_bits & $past(bus_wdata)) == $past(bus_wdata)
        && (channel_enable_bits & $past(channel_enable_bits)) == $past(channel_enable_bits);
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("Enable set wrong");

  property p_enable_clr;
    acc_wr && is_reg(bus_addr, OFF_ENABLE_CLR) |=> (channel_enable_bits & $past(bus_wdata)) == 0;
  endproperty
  a_enable_clr: assert property (p_enable_clr) else $error("Enable clear wrong");

  property p_soft_set;
    acc_wr && is_reg(bus_addr, OFF_SOFT_SET) |=> (raw_source_bits & $past(bus_wdata)) == $past(bus_wdata);
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("Soft trigger not set");

  property p_soft_clr;
    acc_wr && is_reg(bus_addr, OFF_SOFT_CLR) |=> (soft_trigger_bits & $past(bus_wdata)) == 0;
  endproperty
  a_soft_clr: assert property (p_soft_clr) else $error("Soft trigger not cleared");

  property p_refused;
    s_refused |-> ##2 (bus_ack && bus_error && bus_rdata == 16'h0000);
  endproperty
  a_refused: assert property (p_refused) else $error("Refused access answered wrongly");

  property p_var_hit;
    s_var_hit |=> in_service != 16'h0000 ##0 $countones(in_service) == $countones($past(in_service)) + 1;
  endproperty
  a_var_hit: assert property (p_var_hit) else $error("Service not marked");

  property p_var_end;
    var_wr && in_service != 16'h0000 |=> $countones(in_service) == $countones($past(in_service)) - 1;
  endproperty
  a_var_end: assert property (p_var_end) else $error("Service not ended");

  property p_raw_read;
    acc_rd && is_reg(bus_addr, OFF_RAW_STATUS) |-> ##2 bus_rdata == $past(raw_source_bits, 2);
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("Raw status mismatch");

  property p_default;
    s_var_miss |-> ##2 (bus_ack && bus_rdata == $past(fallback_handler_field, 2));
  endproperty
  a_default: assert property (p_default) else $error("Fallback address not returned");
endmodule

// >>> tb/vec_cpu_model.sv
`timescale 1ns/10ps
// Processor side of the register port: one access in flight, no overlap
module vec_cpu_model (
  // Clock
  input wire logic clk_sys,
  // Request
  output logic bus_req,
  output logic bus_write,
  output logic bus_priv,
  output logic [vec_pkg::ADDR_W-1:0] bus_addr,
  output logic [vec_pkg::DATA_W-1:0] bus_wdata,
  // Answer
  input wire logic bus_ack,
  input wire logic bus_error,
  input wire logic [vec_pkg::DATA_W-1:0] bus_rdata
);
  import vec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial begin
    bus_req = 1'b0;
    bus_write = 1'b0;
    bus_priv = 1'b1;
    bus_addr = 12'h000;
    bus_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One access: request held for its taking edge, answer sampled at an edge
  // The caller sets channels, routes and slots up front, keeps privilege
  // on by default and rereads the current vector inside a service to check blocking
  task automatic access(input logic wr, input logic priv, input logic [ADDR_W-1:0] addr,
                        input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
                        output logic err);
    int n;
    @(posedge clk_sys);
    bus_req <= 1'b1;
    bus_write <= wr;
    bus_priv <= priv;
    bus_addr <= addr;
    bus_wdata <= wdata;
    @(posedge clk_sys);
    bus_req <= 1'b0;
    // Released fields go to their inverse so a late sample shows garbage
    bus_addr <= ~addr;
    bus_wdata <= ~wdata;
    rdata = 'x;
    err = 1'bx;
    for (n = 0; n < 6; n++) begin
      @(posedge clk_sys);
      if (bus_ack === 1'b1) begin
        rdata = bus_rdata;
        err = bus_error;
        break;
      end
    end
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import vec_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic [NUM_CH-1:0] irq_source;
  logic bus_req, bus_write, bus_priv, bus_ack, bus_error, irq_out, fiq_out;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata;
  int miscompares = 0;
  int samples_checked = 0;
  logic [11:0] rst_tab [14] = '{OFF_IRQ_STATUS, OFF_FIQ_STATUS, OFF_RAW_STATUS, OFF_ROUTE,
    OFF_ENABLE_SET, OFF_ENABLE_CLR, OFF_SOFT_SET, OFF_SOFT_CLR, OFF_PROTECT, OFF_ACTIVE,
    OFF_FALLBACK, OFF_SLOT_ADDR, OFF_SLOT_ADDR + 12'h03c, OFF_SLOT_CTRL + 12'h03c};

  ////////////////////////////////////////////////////////////////////////////
  vec_intc u_vec_intc (.clk_sys(clk_sys), .reset_n(reset_n), .irq_source(irq_source),
    .bus_req(bus_req), .bus_write(bus_write), .bus_priv(bus_priv), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_error(bus_error),
    .bus_rdata(bus_rdata), .irq_out(irq_out), .fiq_out(fiq_out));
  vec_cpu_model u_vec_cpu_model (.clk_sys(clk_sys), .bus_req(bus_req),
    .bus_write(bus_write), .bus_priv(bus_priv), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_error(bus_error),
    .bus_rdata(bus_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Access with expected data and error flag; writes answer with zero data
  task automatic xfer(input logic w, input logic p, input logic [11:0] a,
                      input logic [15:0] wd, input logic [15:0] e, input logic ee,
                      input string nm);
    logic [15:0] d;
    logic er;
    u_vec_cpu_model.access(w, p, a, wd, d, er);
    check(nm, d, e);
    check({nm, " error"}, {15'h0000, er}, {15'h0000, ee});
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] wd);
    xfer(1'b1, 1'b1, a, wd, 16'h0000, 1'b0, "write");
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e, input string nm);
    xfer(1'b0, 1'b1, a, 16'h0000, e, 1'b0, nm);
  endtask

  // Sources pass a synchronizer before reaching status
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    reset_n = 1'b0;
    irq_source = 16'h0000;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      rd(rst_tab[i], RST_WORD, "reset value");
    end
    // Set-only and clear-only enables
    wr(OFF_ENABLE_SET, 16'h00ff);
    wr(OFF_ENABLE_SET, 16'h0000);
    rd(OFF_ENABLE_SET, 16'h00ff, "enable after zero write");
    wr(OFF_ENABLE_CLR, 16'h000f);
    wr(OFF_ENABLE_CLR, 16'h0000);
    rd(OFF_ENABLE_SET, 16'h00f0, "enable after clear");
    rd(OFF_ENABLE_CLR, 16'h0000, "enable clear readback");
    // Software triggers, masking and routing
    wr(OFF_SOFT_SET, 16'h0030);
    wr(OFF_SOFT_SET, 16'h0000);
    rd(OFF_RAW_STATUS, 16'h0030, "raw soft");
    rd(OFF_IRQ_STATUS, 16'h0030, "irq status soft");
    check("irq out", {15'h0000, irq_out}, 16'h0001);
    wr(OFF_ROUTE, 16'h0020);
    rd(OFF_IRQ_STATUS, 16'h0010, "irq status routed");
    rd(OFF_FIQ_STATUS, 16'h0020, "fiq status routed");
    check("fiq out", {15'h0000, fiq_out}, 16'h0001);
    wr(OFF_SOFT_CLR, 16'h0010);
    wr(OFF_SOFT_CLR, 16'h0000);
    rd(OFF_RAW_STATUS, 16'h0020, "raw after soft clear");
    rd(OFF_SOFT_CLR, 16'h0000, "soft clear readback");
    // Peripheral source follows the line, masked until enabled
    irq_source <= 16'h0100;
    settle();
    rd(OFF_RAW_STATUS, 16'h0120, "raw with source");
    rd(OFF_IRQ_STATUS, 16'h0000, "irq status masked");
    wr(OFF_ENABLE_SET, 16'h0100);
    repeat (20) @(posedge clk_sys);
    rd(OFF_IRQ_STATUS, 16'h0100, "irq status held");
    irq_source <= 16'h0000;
    settle();
    rd(OFF_IRQ_STATUS, 16'h0000, "irq status released");
    check("irq out idle", {15'h0000, irq_out}, 16'h0000);
    // Vectoring: channel 8 in slot 2, channel 4 in slot 5
    wr(OFF_ROUTE, 16'h0000);
    wr(OFF_SOFT_CLR, 16'hffff);
    wr(OFF_FALLBACK, 16'h0bad);
    wr(OFF_SLOT_ADDR + 12'h008, 16'h1a20);
    wr(OFF_SLOT_ADDR + 12'h014, 16'h1a50);
    wr(OFF_SLOT_CTRL + 12'h008, 16'h0028);
    wr(OFF_SLOT_CTRL + 12'h014, 16'h0024);
    rd(OFF_SLOT_ADDR + 12'h008, 16'h1a20, "slot address readback");
    rd(OFF_SLOT_CTRL + 12'h008, 16'h0028, "slot control readback");
    wr(OFF_SOFT_SET, 16'h0010);
    irq_source <= 16'h0100;
    settle();
    rd(OFF_ACTIVE, 16'h1a20, "vector highest");
    rd(OFF_ACTIVE, 16'h0bad, "vector lower blocked");
    wr(OFF_ACTIVE, 16'h0000);
    rd(OFF_ACTIVE, 16'h1a20, "vector after service end");
    wr(OFF_ACTIVE, 16'h0000);
    wr(OFF_SLOT_CTRL + 12'h008, 16'h0008);
    rd(OFF_ACTIVE, 16'h1a50, "vector slot disabled");
    wr(OFF_ACTIVE, 16'h0000);
    // Source code 20 names no channel, so only the fallback can answer
    wr(OFF_SLOT_CTRL + 12'h014, 16'h0034);
    rd(OFF_ACTIVE, 16'h0bad, "vector source out of range");
    irq_source <= 16'h0000;
    // Protection
    wr(OFF_PROTECT, 16'hffff);
    rd(OFF_PROTECT, 16'h0001, "protect readback");
    xfer(1'b0, 1'b0, OFF_ROUTE, 16'h0000, 16'h0000, 1'b1, "user read");
    xfer(1'b1, 1'b0, OFF_FALLBACK, 16'h1234, 16'h0000, 1'b1, "user write");
    rd(OFF_FALLBACK, 16'h0bad, "fallback kept");
    wr(OFF_PROTECT, 16'h0000);
    xfer(1'b0, 1'b0, OFF_FALLBACK, 16'h0000, 16'h0bad, 1'b0, "user open");
    xfer(1'b0, 1'b1, 12'h040, 16'h0000, 16'h0000, 1'b1, "unmapped");
    print_verdict();
  end
endmodule
